// File: include/sibl_pkg.sv
`include "sibl_regs.svh"
package sibl_pkg;

    typedef enum logic [3:0] {
        S_VER    = 4'h0,
        S_RECOV  = 4'h1,
        S_CHECK  = 4'h3,
        S_RUN    = 4'h2,
        S_BANNER = 4'h6,
        S_WAIT   = 4'h7,
        S_BLK    = 4'h5,
        S_WRITE  = 4'h4
    } sibl_state_t;

    typedef struct packed {
        sibl_state_t              state;
        logic [7:0]               tx_data;
        logic                     tx_valid;
        logic [7:0]               pend;
        logic                     pend_v;
        logic [5:0]               idx;
        logic [31:0]              timer;
        logic [55:0]              hist;
        logic [10:0]              pos;
        logic [10:0]              len;
        logic [7:0]               blk;
        logic [7:0]               exp_blk;
        logic [7:0]               rx_crc_hi;
        logic [15:0]              crc;
        logic                     started;
        logic [10:0]              wr_idx;
        logic [`SIBL_ADDR_W-1:0]  base;
        logic                     launch;
        logic                     invalidate;
        logic                     flash_we;
        logic [`SIBL_ADDR_W-1:0]  flash_addr;
        logic [7:0]               flash_data;
    } sibl_regs_t;

endpackage

// File: include/sibl_regs.svh
`ifndef SIBL_REGS_SVH
`define SIBL_REGS_SVH

`define SIBL_CLK_HZ         100000000
`define SIBL_POLL_MS        3000
`define SIBL_RECOV_MS       2000
`define SIBL_CHAR_TO_MS     1000
`define SIBL_MS_CYCLES(ms)  ((ms) * (`SIBL_CLK_HZ / 1000))

`define SIBL_CH_SOH         8'h01
`define SIBL_CH_STX         8'h02
`define SIBL_CH_EOT         8'h04
`define SIBL_CH_ACK         8'h06
`define SIBL_CH_NAK         8'h15
`define SIBL_CH_CAN         8'h18
`define SIBL_CH_CR          8'h0D
`define SIBL_CH_POLL        8'h43
`define SIBL_INV_PAIR       8'hFF

`define SIBL_LEN_1K         11'h400
`define SIBL_LEN_128        11'h080
`define SIBL_FIRST_BLK      8'h01

`define SIBL_ADDR_W         24
`define SIBL_APP_BASE       24'h010000
`define SIBL_APP_LIMIT      24'h100000

`define SIBL_KW_UPLOAD      48'h75706C6F6164
`define SIBL_KW_RECOVER     56'h7265636F766572

`define SIBL_VER_LEN        6'h12
`define SIBL_VER_STR        "BOOTLOADER v1.00\015\012"
`define SIBL_BAN_LEN        6'h34
`define SIBL_BAN_STR        "Waiting for XMODEM 1K with CRC.\015\012Control X aborts.\015\012"

`endif

// File: verif/sibl_host.sv
`timescale 1ns/1ps
module sibl_host (
    input  wire logic       mclk,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid
);
    logic [7:0] got[$];
    logic       slow = 1'b0;
    initial begin
        tx_ready = 1'b0;
        rx_data  = 8'h00;
        rx_valid = 1'b0;
    end
    // Slow mode stalls every other slot, like a busy terminal
    always @(posedge mclk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
    // Whole 8-bit characters; idle line shows the inverse of the last one
    task automatic send(input logic [7:0] b);
        @(posedge mclk);
        rx_data  <= b;
        rx_valid <= 1'b1;
        @(posedge mclk);
        rx_data  <= ~b;
        rx_valid <= 1'b0;
    endtask
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int k = 0; k < 8; k++)
            c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
        return c;
    endfunction
    // Block of 1024 or 128 data bytes with CRC16; bad corrupts the trailing CRC
    task automatic send_block(input logic [7:0] blk, input logic bad, input int len);
        logic [15:0] crc;
        logic [7:0]  d;
        crc = 16'h0000;
        send((len == 1024) ? 8'h02 : 8'h01);
        send(blk);
        send(~blk);
        for (int i = 0; i < len; i++) begin
            d = 8'(i * 3) ^ blk;
            crc = crc_step(crc, d);
            send(d);
        end
        send(crc[15:8] ^ {7'h00, bad});
        send(crc[7:0]);
    endtask
    // Operator typing on the console
    task automatic type_str(input string s);
        for (int i = 0; i < s.len(); i++)
            send(s[i]);
    endtask
endmodule

// File: verif/sibl_monitor.sv
`timescale 1ns/1ps
module sibl_monitor #(
    parameter int POLL_CYC = 200
) (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic        wdt_expire,
    input wire logic        flash_we,
    input wire logic [23:0] flash_addr,
    input wire logic        app_invalidate,
    input wire logic        launch_app
);
    logic [31:0] gap;
    logic        last_c;
    logic [10:0] wcnt;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // Gap and write count restart on every accepted byte
    always_ff @(posedge mclk) begin
        if (sys_rst || (tx_valid && tx_ready)) begin
            gap    <= 32'h00000000;
            last_c <= !sys_rst && tx_data == 8'h43;
            wcnt   <= 11'h000;
        end else begin
            if (gap != 32'hFFFFFFFF) gap <= gap + 32'h00000001;
            if (flash_we) wcnt <= wcnt + 11'h001;
        end
    end
    chk_tx_hold:
        assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte changed before accept");
    chk_boot_region:
        assert property (flash_we |-> flash_addr >= 24'h010000 && flash_addr < 24'h100000)
        else $error("flash write outside application area");
    chk_inval_pulse:
        assert property (app_invalidate |=> !app_invalidate)
        else $error("invalidate longer than one cycle");
    chk_launch_quiet:
        assert property (launch_app |-> !tx_valid && !flash_we)
        else $error("loader active while image runs");
    chk_wdt_stop:
        assert property (launch_app && wdt_expire |-> ##[1:2] !launch_app)
        else $error("watchdog did not stop image");
    chk_reset_quiet:
        assert property (disable iff (1'b0) sys_rst |=> !tx_valid && !flash_we && !launch_app)
        else $error("outputs active in reset");
    chk_boot_ver:
        assert property ($fell(sys_rst) |-> ##[1:2] tx_valid && tx_data == 8'h42)
        else $error("version string not started after reset");
    chk_ack_block:
        assert property (flash_we && wcnt == 11'h3FF |-> ##[1:4] tx_valid && tx_data == 8'h06)
        else $error("no ack after block write");
    chk_poll_gap:
        assert property (tx_valid && tx_ready && tx_data == 8'h43 && last_c
                         |-> gap >= POLL_CYC - 3 && gap <= POLL_CYC + 3)
        else $error("poll period wrong");
    cover property (app_invalidate);
    cover property (launch_app && wdt_expire);
    cover property (flash_we && wcnt == 11'h3FF);
endmodule

bind sibl_loader sibl_monitor #(.POLL_CYC(POLL_CYC)) u_mon (.mclk, .sys_rst, .tx_data,
    .tx_valid, .tx_ready, .wdt_expire, .flash_we, .flash_addr, .app_invalidate, .launch_app);

// File: verif/tb_serial_image_boot_loader.sv
`timescale 1ns/1ps
`include "sibl_regs.svh"
module tb_serial_image_boot_loader;
    localparam int POLL  = 200;
    localparam int RECOV = 300;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        app_valid = 1'b0;
    logic        wdt_expire = 1'b0;
    logic        flash_ready = 1'b0;
    logic        flash_we, tx_valid, tx_ready, rx_valid, app_invalidate, launch_app;
    logic [7:0]  tx_data, rx_data, flash_data;
    logic [23:0] flash_addr;
    logic [7:0]  fl[1024];
    int          errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          wr_cnt = 0;
    int          inv_cnt = 0;
    int          bad_addr = 0;
    always #5 mclk = ~mclk;
    sibl_loader #(.POLL_CYC(POLL), .RECOV_CYC(RECOV), .CHAR_TO_CYC(100)) DUT (.mclk, .sys_rst,
        .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready, .app_valid, .wdt_expire,
        .flash_ready, .flash_we, .flash_addr, .flash_data, .app_invalidate, .launch_app);
    sibl_host HOST (.mclk, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid);
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        flash_ready <= HOST.slow ? !flash_ready : 1'b1;
        if (flash_we) begin
            wr_cnt <= wr_cnt + 1;
            fl[flash_addr[9:0]] <= flash_data;
            if (flash_addr[23:10] != 14'h0040) bad_addr <= bad_addr + 1;
        end
        if (app_invalidate) inv_cnt <= inv_cnt + 1;
        if (cyc == 40000) begin
            errors++;
            test_done();
        end
    end
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s: expected %b, seen %b", what, exp, got);
        end
    endtask
    task automatic get_byte(output logic [7:0] b);
        b = 8'hXX;
        for (int i = 0; i < 4000 && HOST.got.size() == 0; i++)
            @(posedge mclk);
        if (HOST.got.size() != 0) b = HOST.got.pop_front();
    endtask
    task automatic expect_str(input string s);
        logic [7:0] b;
        for (int i = 0; i < s.len(); i++) begin
            get_byte(b);
            check_byte("console byte", s[i], b);
        end
    endtask
    task automatic t_boot_empty();
        logic [7:0] b;
        int         t0;
        expect_str(`SIBL_VER_STR);
        get_byte(b);
        check_byte("first poll", 8'h43, b);
        t0 = cyc;
        get_byte(b);
        check_byte("second poll", 8'h43, b);
        check_bit("poll period", 1'b1, (cyc - t0) inside {[POLL - 3 : POLL + 3]});
        app_valid <= 1'b1;
        HOST.send(`SIBL_CH_CAN);
        repeat (20) @(posedge mclk);
        check_bit("launch after cancel", 1'b1, launch_app);
        check_bit("image untouched", 1'b1, wr_cnt == 0 && inv_cnt == 0);
    endtask
    task automatic t_load();
        logic [7:0] b;
        int         ok = 1;
        HOST.type_str("upload\015");
        app_valid <= 1'b0;
        expect_str(`SIBL_BAN_STR);
        check_bit("app stopped", 1'b0, launch_app);
        get_byte(b);
        check_byte("poll after banner", 8'h43, b);
        HOST.send_block(8'h01, 1'b0, 1024);
        get_byte(b);
        check_byte("good block", `SIBL_CH_ACK, b);
        for (int i = 0; i < 1024; i++)
            if (fl[i] !== (8'(i * 3) ^ 8'h01)) ok = 0;
        check_bit("flash image", 1'b1, ok == 1 && wr_cnt == 1024);
        check_bit("region and invalidate", 1'b1, bad_addr == 0 && inv_cnt == 1);
        HOST.send_block(8'h01, 1'b0, 128);
        get_byte(b);
        check_byte("repeated short block", `SIBL_CH_ACK, b);
        HOST.slow <= 1'b1;
        HOST.send_block(8'h02, 1'b1, 1024);
        get_byte(b);
        check_byte("bad crc", `SIBL_CH_NAK, b);
        get_byte(b);
        check_byte("no poll once started", `SIBL_CH_NAK, b);
        HOST.send(`SIBL_CH_EOT);
        get_byte(b);
        check_byte("end of file", `SIBL_CH_ACK, b);
        expect_str(`SIBL_VER_STR);
        check_bit("bad block not written", 1'b1, wr_cnt == 1024);
    endtask
    // Corrupt but valid-looking image keeps rebooting until recovered
    task automatic t_wdt();
        logic [7:0] b;
        app_valid <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            repeat (RECOV + 20) @(posedge mclk);
            check_bit("corrupt image runs", 1'b1, launch_app);
            HOST.got.delete();
            wdt_expire <= 1'b1;
            @(posedge mclk);
            wdt_expire <= 1'b0;
            expect_str(`SIBL_VER_STR);
        end
        HOST.type_str("recover");
        expect_str(`SIBL_BAN_STR);
        get_byte(b);
        check_byte("poll after recover", 8'h43, b);
        check_bit("image bypassed", 1'b0, launch_app);
    endtask
    task automatic test_done();
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        t_boot_empty();
        t_load();
        t_wdt();
        test_done();
    end
endmodule

// File: verilog/sibl_crc16.sv
`timescale 1ns/1ps
// One byte step of the XMODEM CRC, polynomial 0x1021, MSB first
module sibl_crc16 (
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc_out
);
    always_comb begin
        logic [15:0] c;
        c = crc_in ^ {data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
        end
        crc_out = c;
    end
endmodule

// File: verilog/sibl_loader.sv
`timescale 1ns/1ps
`include "sibl_regs.svh"
module sibl_loader #(
    parameter int POLL_CYC    = `SIBL_MS_CYCLES(`SIBL_POLL_MS),
    parameter int RECOV_CYC   = `SIBL_MS_CYCLES(`SIBL_RECOV_MS),
    parameter int CHAR_TO_CYC = `SIBL_MS_CYCLES(`SIBL_CHAR_TO_MS)
) (
    input  wire logic                    mclk,
    input  wire logic                    sys_rst,
    input  wire logic [7:0]              rx_data,
    input  wire logic                    rx_valid,
    output logic      [7:0]              tx_data,
    output logic                         tx_valid,
    input  wire logic                    tx_ready,
    input  wire logic                    app_valid,
    input  wire logic                    wdt_expire,
    input  wire logic                    flash_ready,
    output logic                         flash_we,
    output logic      [`SIBL_ADDR_W-1:0] flash_addr,
    output logic      [7:0]              flash_data,
    output logic                         app_invalidate,
    output logic                         launch_app
);
    import sibl_pkg::*;

    localparam logic [`SIBL_VER_LEN*8-1:0] VER_MSG = `SIBL_VER_STR;
    localparam logic [`SIBL_BAN_LEN*8-1:0] BAN_MSG = `SIBL_BAN_STR;

    sibl_regs_t r;
    sibl_regs_t n;
    logic [7:0]  blk_buf [0:1023];
    logic [15:0] crc_nx;
    logic [55:0] hist_nx;
    logic        tx_free;
    logic        data_byte;
    logic        good;

    sibl_crc16 u_crc (
        .crc_in  (r.crc),
        .data    (rx_data),
        .crc_out (crc_nx)
    );

    assign tx_free   = !r.tx_valid || tx_ready;
    assign hist_nx   = {r.hist[47:0], rx_data};
    assign data_byte = (r.pos >= 11'd2) && (r.pos < r.len + 11'd2);
    // CRC compare of a block, valid when the low CRC byte arrives; pair check sits in pend
    assign good      = ({r.rx_crc_hi, rx_data} == r.crc);

    // Block payload is held until its CRC passes; flash never sees a bad block
    always_ff @(posedge mclk) begin
        if (r.state == S_BLK && rx_valid && data_byte) begin
            blk_buf[r.pos[9:0] - 10'd2] <= rx_data;
        end
    end

    always_comb begin
        n = r;
        n.flash_we   = 1'b0;
        n.invalidate = 1'b0;
        n.timer      = r.timer + 32'd1;
        if (rx_valid) begin
            n.hist = hist_nx;
        end
        if (r.tx_valid && tx_ready) begin
            n.tx_valid = 1'b0;
        end
        if (tx_free && r.pend_v) begin
            n.tx_data  = r.pend;
            n.tx_valid = 1'b1;
            n.pend_v   = 1'b0;
        end
        case (r.state)
            S_VER: begin
                n.launch = 1'b0;
                if (tx_free && !r.pend_v) begin
                    if (r.idx == `SIBL_VER_LEN) begin
                        n.state = S_RECOV;
                        n.timer = 32'd0;
                        n.hist  = 56'h0;
                    end else begin
                        n.tx_data  = VER_MSG[(`SIBL_VER_LEN - 6'd1 - r.idx) * 8 +: 8];
                        n.tx_valid = 1'b1;
                        n.idx      = r.idx + 6'd1;
                    end
                end
            end
            S_RECOV: begin
                if (rx_valid && hist_nx == `SIBL_KW_RECOVER) begin
                    n.state = S_BANNER;
                    n.idx   = 6'd0;
                end else if (r.timer >= 32'(RECOV_CYC - 1)) begin
                    n.state = S_CHECK;
                end
            end
            S_CHECK: begin
                n.started = 1'b0;
                n.exp_blk = `SIBL_FIRST_BLK;
                n.base    = `SIBL_APP_BASE;
                if (app_valid) begin
                    n.state  = S_RUN;
                    n.launch = 1'b1;
                end else begin
                    n.state = S_WAIT;
                    n.timer = 32'(POLL_CYC - 1);
                end
            end
            S_RUN: begin
                // The loader stays idle under a running image but snoops for the upload command
                if (wdt_expire) begin
                    n.state  = S_VER;
                    n.idx    = 6'd0;
                    n.launch = 1'b0;
                end else if (rx_valid && rx_data == `SIBL_CH_CR &&
                             r.hist[47:0] == `SIBL_KW_UPLOAD) begin
                    n.state  = S_BANNER;
                    n.idx    = 6'd0;
                    n.launch = 1'b0;
                end
            end
            S_BANNER: begin
                n.launch = 1'b0;
                if (tx_free && !r.pend_v) begin
                    if (r.idx == `SIBL_BAN_LEN) begin
                        n.state   = S_WAIT;
                        n.timer   = 32'(POLL_CYC - 1);
                        n.started = 1'b0;
                        n.exp_blk = `SIBL_FIRST_BLK;
                        n.base    = `SIBL_APP_BASE;
                    end else begin
                        n.tx_data  = BAN_MSG[(`SIBL_BAN_LEN - 6'd1 - r.idx) * 8 +: 8];
                        n.tx_valid = 1'b1;
                        n.idx      = r.idx + 6'd1;
                    end
                end
            end
            S_WAIT: begin
                if (rx_valid && (rx_data == `SIBL_CH_STX || rx_data == `SIBL_CH_SOH)) begin
                    n.state = S_BLK;
                    n.len   = (rx_data == `SIBL_CH_STX) ? `SIBL_LEN_1K : `SIBL_LEN_128;
                    n.pos   = 11'd0;
                    n.crc   = 16'h0000;
                    n.timer = 32'd0;
                end else if (rx_valid && rx_data == `SIBL_CH_CAN) begin
                    // Before any block the image is untouched; after, it was already invalidated
                    n.state = S_CHECK;
                end else if (rx_valid && rx_data == `SIBL_CH_EOT && r.started) begin
                    n.pend   = `SIBL_CH_ACK;
                    n.pend_v = 1'b1;
                    n.state  = S_VER;
                    n.idx    = 6'd0;
                end else if (!r.started) begin
                    if (r.timer >= 32'(POLL_CYC - 1) && !r.pend_v) begin
                        n.pend   = `SIBL_CH_POLL;
                        n.pend_v = 1'b1;
                        n.timer  = 32'd0;
                    end
                end else if (r.timer >= 32'(CHAR_TO_CYC - 1) && !r.pend_v) begin
                    n.pend   = `SIBL_CH_NAK;
                    n.pend_v = 1'b1;
                    n.timer  = 32'd0;
                end
            end
            S_BLK: begin
                if (rx_valid) begin
                    n.timer = 32'd0;
                    n.pos   = r.pos + 11'd1;
                    if (r.pos == 11'd0) begin
                        n.blk = rx_data;
                    end else if (r.pos == 11'd1) begin
                        n.rx_crc_hi = rx_data ^ r.blk; // pair XOR, FF when valid
                    end else if (data_byte) begin
                        n.crc = crc_nx;
                    end else if (r.pos == r.len + 11'd2) begin
                        n.rx_crc_hi = rx_data;
                        n.pend      = (r.rx_crc_hi == `SIBL_INV_PAIR) ? 8'h00 : 8'hFF;
                    end else begin
                        n.pend_v = 1'b1;
                        n.state  = S_WAIT;
                        n.pend   = `SIBL_CH_NAK;
                        if (r.pend == 8'h00 && good) begin
                            if (r.blk == r.exp_blk) begin
                                n.pend_v = 1'b0;
                                n.state  = S_WRITE;
                                n.wr_idx = 11'd0;
                                if (!r.started) begin
                                    n.invalidate = 1'b1;
                                    n.started    = 1'b1;
                                end
                            end else if (r.blk == r.exp_blk - 8'd1) begin
                                n.pend = `SIBL_CH_ACK;
                            end
                        end
                    end
                end else if (r.timer >= 32'(CHAR_TO_CYC - 1)) begin
                    n.state  = S_WAIT;
                    n.pend   = `SIBL_CH_NAK;
                    n.pend_v = 1'b1;
                    n.timer  = 32'd0;
                end
            end
            S_WRITE: begin
                if (flash_ready) begin
                    n.flash_addr = r.base + `SIBL_ADDR_W'(r.wr_idx);
                    n.flash_data = blk_buf[r.wr_idx[9:0]];
                    // Image offsets start above the loader and stop at the flash end
                    n.flash_we = (n.flash_addr >= `SIBL_APP_BASE) &&
                                 (n.flash_addr < `SIBL_APP_LIMIT);
                    n.wr_idx = r.wr_idx + 11'd1;
                    if (r.wr_idx == r.len - 11'd1) begin
                        n.base    = r.base + `SIBL_ADDR_W'(r.len);
                        n.exp_blk = r.exp_blk + 8'd1;
                        n.pend    = `SIBL_CH_ACK;
                        n.pend_v  = 1'b1;
                        n.state   = S_WAIT;
                        n.timer   = 32'd0;
                    end
                end
            end
            default: begin
                n.state = S_VER;
                n.idx   = 6'd0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tx_data        = r.tx_data;
    assign tx_valid       = r.tx_valid;
    assign flash_we       = r.flash_we;
    assign flash_addr     = r.flash_addr;
    assign flash_data     = r.flash_data;
    assign app_invalidate = r.invalidate;
    assign launch_app     = r.launch;
endmodule
